// ---- design/twd_debug_port.v ----
`timescale 1ns/1ps
// Overview of operation
// - Two pins only: shared bidirectional data line and input-only clock line.
// - These registers are reachable only through the two-wire debug link.
// - 8-bit read/write select pointer, reset zero, picks data command target.
// - Pointer 0x00 reads return the device identity code.
// - Pointer 0x01 reads return the silicon revision code.
// - Pointer 0x02 data commands access flash programming control.
// - Pointer 0xBF data commands access flash programming data.
// - Pointers 0x96, 0x97, 0x91 reach CRC auto, count, control registers.
// - Pointers 0xD9, 0x95, 0x94 reach CRC result, reversal, input registers.
// - Flash data accepts block read, block write, page erase, device erase.
`include "twd_defines.vh"
module twd_debug_port #(
  // Arbitrary identity values, not those of any real part.
  parameter [7:0] DEVICE_IDENTITY = 8'h5a,
  parameter [7:0] SILICON_REVISION = 8'h00
) (
  // Clock and reset.
  input wire ref_clk,
  input wire resetn,
  // Debug link pins.
  input wire debug_clock_line,
  input wire debug_data_line_i,
  output reg debug_data_line_o,
  output reg debug_data_line_oe,
  // Flash programming side.
  output reg flash_prog_enable,
  output reg flash_cmd_valid,
  output reg [7:0] flash_cmd_code,
  output reg flash_data_wr,
  output reg [7:0] flash_data_wdata,
  input wire [7:0] flash_data_rdata,
  // CRC unit side.
  output reg crc_wr,
  output reg crc_rd,
  output reg [7:0] crc_sel,
  output reg [7:0] crc_wdata,
  input wire [7:0] crc_rdata,
  // Status.
  output reg [7:0] register_select_pointer
);
  // ==========================================================================
  // Frame states.
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_INS = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_TURN = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;
  localparam [2:0] ST_STOP = 3'h5;

  function is_crc;
    input [7:0] sel;
    begin
      is_crc = (sel == `TWD_SEL_CRC_AUTO) || (sel == `TWD_SEL_CRC_CNT) ||
        (sel == `TWD_SEL_CRC_CTL) || (sel == `TWD_SEL_CRC_DATA) ||
        (sel == `TWD_SEL_CRC_FLIP) || (sel == `TWD_SEL_CRC_IN);
    end
  endfunction

  function is_flash_cmd;
    input [7:0] code;
    begin
      is_flash_cmd = (code == `TWD_CMD_BLK_RD) || (code == `TWD_CMD_BLK_WR) ||
        (code == `TWD_CMD_PG_ERASE) || (code == `TWD_CMD_DEV_ERASE);
    end
  endfunction

  // ==========================================================================
  // Pin synchronisers; the link clock is sampled, never used as a clock.
  reg ck_s1_q;
  reg ck_s2_q;
  reg ck_s3_q;
  reg d_s1_q;
  reg d_s2_q;
  always @(posedge ref_clk) begin
    if (!resetn) begin
      ck_s1_q <= 1'b1;
      ck_s2_q <= 1'b1;
      ck_s3_q <= 1'b1;
      d_s1_q <= 1'b0;
      d_s2_q <= 1'b0;
    end else begin
      ck_s1_q <= debug_clock_line;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      d_s1_q <= debug_data_line_i;
      d_s2_q <= d_s1_q;
    end
  end
  // Data is sampled on the rising edge; the device drives after the falling edge.
  wire ck_rise = ck_s2_q & ~ck_s3_q;
  wire ck_fall = ~ck_s2_q & ck_s3_q;

  // ==========================================================================
  // Frame engine.
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg [1:0] ins_q;
  reg [7:0] sh_q;
  reg [7:0] rd_byte_q;
  reg fp_key_q;
  reg [7:0] flash_program_control_q;
  reg [7:0] read_mux;

  // Read data chosen from the pointer at the turnaround.
  always @* begin
    read_mux = `TWD_REG_RESET;
    if (register_select_pointer == `TWD_SEL_IDENT)
      read_mux = DEVICE_IDENTITY;
    else if (register_select_pointer == `TWD_SEL_REV)
      read_mux = SILICON_REVISION;
    else if (register_select_pointer == `TWD_SEL_FLASH_PROGRAM_CONTROL)
      read_mux = flash_program_control_q;
    else if (register_select_pointer == `TWD_SEL_FLASH_PROGRAM_DATA)
      read_mux = flash_data_rdata;
    else if (is_crc(register_select_pointer))
      read_mux = crc_rdata;
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      ins_q <= 2'h0;
      sh_q <= `TWD_REG_RESET;
      rd_byte_q <= `TWD_REG_RESET;
      register_select_pointer <= `TWD_PTR_RESET;
      flash_program_control_q <= `TWD_REG_RESET;
      fp_key_q <= 1'b0;
      flash_prog_enable <= 1'b0;
      flash_cmd_valid <= 1'b0;
      flash_cmd_code <= `TWD_REG_RESET;
      flash_data_wr <= 1'b0;
      flash_data_wdata <= `TWD_REG_RESET;
      crc_wr <= 1'b0;
      crc_rd <= 1'b0;
      crc_sel <= `TWD_REG_RESET;
      crc_wdata <= `TWD_REG_RESET;
      debug_data_line_o <= 1'b0;
      debug_data_line_oe <= 1'b0;
    end else begin
      flash_cmd_valid <= 1'b0;
      flash_data_wr <= 1'b0;
      crc_wr <= 1'b0;
      crc_rd <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          debug_data_line_oe <= 1'b0;
          // A start bit is any sampled rising clock edge; the first bit is ignored.
          if (ck_rise) begin
            state_q <= ST_INS;
            cnt_q <= 4'h0;
          end
        end
        ST_INS: begin
          if (ck_rise) begin
            ins_q <= {d_s2_q, ins_q[1]};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `TWD_INS_BITS - 4'h1) begin
              cnt_q <= 4'h0;
              if ({d_s2_q, ins_q[1]} == `TWD_INS_ADDR_WR ||
                  {d_s2_q, ins_q[1]} == `TWD_INS_DATA_WR)
                state_q <= ST_WDATA;
              else
                state_q <= ST_TURN;
            end
          end
        end
        ST_WDATA: begin
          if (ck_rise) begin
            sh_q <= {d_s2_q, sh_q[7:1]};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `TWD_BYTE_BITS - 4'h1) begin
              state_q <= ST_STOP;
              if (ins_q == `TWD_INS_ADDR_WR)
                register_select_pointer <= {d_s2_q, sh_q[7:1]};
              else if (register_select_pointer == `TWD_SEL_FLASH_PROGRAM_CONTROL) begin
                // The unlock pair must arrive back to back; only a reset clears it.
                flash_program_control_q <= {d_s2_q, sh_q[7:1]};
                fp_key_q <= ({d_s2_q, sh_q[7:1]} == `TWD_FP_KEY1);
                if (fp_key_q && {d_s2_q, sh_q[7:1]} == `TWD_FP_KEY2)
                  flash_prog_enable <= 1'b1;
              end else if (register_select_pointer == `TWD_SEL_FLASH_PROGRAM_DATA) begin
                flash_data_wr <= 1'b1;
                flash_data_wdata <= {d_s2_q, sh_q[7:1]};
                if (is_flash_cmd({d_s2_q, sh_q[7:1]})) begin
                  flash_cmd_valid <= flash_prog_enable;
                  flash_cmd_code <= {d_s2_q, sh_q[7:1]};
                end
              end else if (is_crc(register_select_pointer)) begin
                crc_wr <= 1'b1;
                crc_sel <= register_select_pointer;
                crc_wdata <= {d_s2_q, sh_q[7:1]};
              end
              // Identity and revision writes fall through untouched.
            end
          end
        end
        ST_TURN: begin
          // The turnaround is a whole link cycle of its own; the falling edge of the last
          // instruction bit must not start the read, or every bit would come one cycle early.
          if (ck_rise)
            cnt_q <= 4'h1;
          if (ck_fall && cnt_q == 4'h1) begin
            state_q <= ST_RDATA;
            cnt_q <= 4'h0;
            rd_byte_q <= (ins_q == `TWD_INS_ADDR_RD) ? register_select_pointer : read_mux;
            debug_data_line_o <= (ins_q == `TWD_INS_ADDR_RD) ?
              register_select_pointer[0] : read_mux[0];
            debug_data_line_oe <= 1'b1;
            if (ins_q == `TWD_INS_DATA_RD && is_crc(register_select_pointer)) begin
              crc_rd <= 1'b1;
              crc_sel <= register_select_pointer;
            end
          end
        end
        ST_RDATA: begin
          if (ck_fall) begin
            cnt_q <= cnt_q + 4'h1;
            debug_data_line_o <= rd_byte_q[cnt_q[2:0] + 3'h1];
            if (cnt_q == `TWD_BYTE_BITS - 4'h1) begin
              debug_data_line_oe <= 1'b0;
              state_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          debug_data_line_oe <= 1'b0;
          if (ck_rise)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ---- design/twd_defines.vh ----
`ifndef TWD_DEFINES_VH
`define TWD_DEFINES_VH
// ==========================================================================
// Register select codes.
`define TWD_SEL_IDENT 8'h00
`define TWD_SEL_REV 8'h01
`define TWD_SEL_FLASH_PROGRAM_CONTROL 8'h02
`define TWD_SEL_FLASH_PROGRAM_DATA 8'hbf
`define TWD_SEL_CRC_AUTO 8'h96
`define TWD_SEL_CRC_CNT 8'h97
`define TWD_SEL_CRC_CTL 8'h91
`define TWD_SEL_CRC_DATA 8'hd9
`define TWD_SEL_CRC_FLIP 8'h95
`define TWD_SEL_CRC_IN 8'h94
// ==========================================================================
// Reset values and codes.
`define TWD_PTR_RESET 8'h00
`define TWD_REG_RESET 8'h00
`define TWD_FP_KEY1 8'h02
`define TWD_FP_KEY2 8'h01
`define TWD_CMD_BLK_RD 8'h06
`define TWD_CMD_BLK_WR 8'h07
`define TWD_CMD_PG_ERASE 8'h08
`define TWD_CMD_DEV_ERASE 8'h03
// ==========================================================================
// Link framing: instruction codes and field widths.
`define TWD_INS_DATA_RD 2'h0
`define TWD_INS_ADDR_WR 2'h3
`define TWD_INS_ADDR_RD 2'h2
`define TWD_INS_DATA_WR 2'h1
`define TWD_BYTE_BITS 4'h8
`define TWD_INS_BITS 4'h2
`define TWD_TURN_BITS 4'h1
`endif

// ---- verif/twd_adapter_model.sv ----
`timescale 1ns/1ps
// ==========
// Adapter: clock idles low between frames; released data line is pulled up.
module twd_adapter_model (
  // Link.
  input wire logic dev_o,
  input wire logic dev_oe,
  output logic link_clk,
  output wire logic link_d
);
  logic drv_d = 1'b1;
  logic drv_oe = 1'b0;
  assign link_d = dev_oe ? dev_o : drv_oe ? drv_d : 1'b1;
  initial link_clk = 1'b0;
  task automatic tick();
    #400 link_clk = 1'b1;
    #400 link_clk = 1'b0;
  endtask
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    drv_oe = 1'b1;
    drv_d = 1'b0;
    tick();
    for (int i = 0; i < 2; i++) begin
      drv_d = ins[i];
      tick();
    end
    if (ins[0]) begin
      for (int i = 0; i < 8; i++) begin
        drv_d = wd[i];
        tick();
      end
    end else begin
      drv_oe = 1'b0;
      tick();
      for (int i = 0; i < 8; i++) begin
        #400 link_clk = 1'b1;
        #400 rd[i] = link_d;
        link_clk = 1'b0;
      end
    end
    drv_oe = 1'b0;
    tick();
  endtask
endmodule

// ---- verif/twd_debug_port_tb.sv ----
`timescale 1ns/1ps
`include "twd_defines.vh"
// ==========
module twd_debug_port_tb;
  localparam logic [7:0] ID = 8'h5a; // Arbitrary code.
  localparam logic [7:0] REV = 8'h01;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] flash_data_rdata = 8'h3c;
  logic [7:0] crc_rdata = 8'ha5;
  wire debug_clock_line, debug_data_line_i, debug_data_line_o, debug_data_line_oe;
  wire flash_prog_enable, flash_cmd_valid, flash_data_wr, crc_wr, crc_rd;
  wire [7:0] flash_cmd_code, flash_data_wdata, crc_sel, crc_wdata, register_select_pointer;
  int miscompares = 0;
  int checks = 0;
  logic [7:0] rd;
  logic [7:0] sels [6] = '{8'h96, 8'h97, 8'h91, 8'hd9, 8'h95, 8'h94};
  logic [7:0] cmds [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
  always #50 ref_clk = ~ref_clk;
  twd_debug_port #(.DEVICE_IDENTITY(ID), .SILICON_REVISION(REV)) twd_debug_port_inst (.ref_clk, .resetn,
    .debug_clock_line, .debug_data_line_i, .debug_data_line_o, .debug_data_line_oe, .flash_prog_enable,
    .flash_cmd_valid, .flash_cmd_code, .flash_data_wr, .flash_data_wdata, .flash_data_rdata, .crc_wr, .crc_rd,
    .crc_sel, .crc_wdata, .crc_rdata, .register_select_pointer);
  twd_adapter_model twd_adapter_model_inst (.dev_o(debug_data_line_o), .dev_oe(debug_data_line_oe),
    .link_clk(debug_clock_line), .link_d(debug_data_line_i));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Settle time lets the stop edge pass the synchroniser.
  task automatic acc(input logic [1:0] ins, input logic [7:0] wd);
    twd_adapter_model_inst.frame(ins, wd, rd);
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    acc(`TWD_INS_ADDR_RD, 8'h00);
    cmp(rd, 8'h00);
    for (int i = 0; i < 2; i++) begin
      acc(`TWD_INS_ADDR_WR, i[7:0]);
      acc(`TWD_INS_DATA_WR, 8'hff);
      acc(`TWD_INS_DATA_RD, 8'h00);
      cmp(rd, i ? REV : ID);
    end
    acc(`TWD_INS_ADDR_WR, `TWD_SEL_FLASH_PROGRAM_CONTROL);
    acc(`TWD_INS_DATA_WR, `TWD_FP_KEY2);
    cmp({7'h00, flash_prog_enable}, 8'h00);
    acc(`TWD_INS_DATA_WR, `TWD_FP_KEY1);
    acc(`TWD_INS_DATA_WR, `TWD_FP_KEY2);
    cmp({7'h00, flash_prog_enable}, 8'h01);
    acc(`TWD_INS_ADDR_WR, `TWD_SEL_FLASH_PROGRAM_DATA);
    foreach (cmds[i]) begin
      acc(`TWD_INS_DATA_WR, cmds[i]);
      cmp(flash_data_wdata, cmds[i]);
      cmp(flash_cmd_code, cmds[i]);
    end
    acc(`TWD_INS_DATA_RD, 8'h00);
    cmp(rd, 8'h3c);
    foreach (sels[i]) begin
      acc(`TWD_INS_ADDR_WR, sels[i]);
      acc(`TWD_INS_ADDR_RD, 8'h00);
      cmp(rd, sels[i]);
      acc(`TWD_INS_DATA_WR, ~sels[i]);
      cmp(crc_sel, sels[i]);
      cmp(crc_wdata, ~sels[i]);
      acc(`TWD_INS_DATA_RD, 8'h00);
      cmp(rd, 8'ha5);
    end
    resetn = 1'b0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    cmp(register_select_pointer, 8'h00);
    close_out();
  end
endmodule

// ---- verif/twd_properties.sv ----
`timescale 1ns/1ps
// ==========
// Checks on the device side of the link.
module twd_properties (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Link and device outputs.
  input wire logic debug_clock_line,
  input wire logic flash_prog_enable,
  input wire logic flash_cmd_valid,
  input wire logic [7:0] flash_cmd_code,
  input wire logic flash_data_wr,
  input wire logic crc_wr,
  input wire logic crc_rd,
  input wire logic [7:0] crc_sel,
  input wire logic [7:0] register_select_pointer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_ptr_reset: assert property ($rose(resetn) |-> register_select_pointer == 8'h00 && !flash_prog_enable)
    else $error("pointer not cleared");
  chk_cmd_lock: assert property (flash_cmd_valid |-> flash_prog_enable)
    else $error("command before unlock");
  chk_cmd_code: assert property (flash_cmd_valid |-> flash_cmd_code inside {8'h06, 8'h07, 8'h08, 8'h03})
    else $error("bad command code");
  chk_cmd_pulse: assert property (flash_cmd_valid |=> !flash_cmd_valid)
    else $error("command pulse too long");
  chk_en_hold: assert property (flash_prog_enable |=> flash_prog_enable)
    else $error("enable dropped");
  chk_fp_sel: assert property (flash_data_wr |-> register_select_pointer == 8'hbf)
    else $error("flash data at wrong address");
  chk_crc_sel: assert property (crc_wr || crc_rd |-> crc_sel == register_select_pointer &&
    crc_sel inside {8'h91, 8'h94, 8'h95, 8'h96, 8'h97, 8'hd9}) else $error("bad crc select");
  // The pointer may only move on link activity, never on its own.
  chk_ptr_link: assert property (!$stable(register_select_pointer) |-> $past(debug_clock_line) || $past(debug_clock_line, 2))
    else $error("pointer moved off link");
endmodule
bind twd_debug_port twd_properties twd_properties_inst (.ref_clk, .resetn, .debug_clock_line, .flash_prog_enable,
  .flash_cmd_valid, .flash_cmd_code, .flash_data_wr, .crc_wr, .crc_rd, .crc_sel, .register_select_pointer);
